/* File: verilog/fcg_gate.sv */
// Purpose: command acceptance and protection of a serial flash
// Assumes: chip select and serial clock are pins, synchronised here
// Notes:   supply monitors arrive as asynchronous level flags
`default_nettype none
// Behaviour
// R01: latency code from configuration bits 7:6
// R02: code sets mode and dummy cycles; here mode cycles come from the command only (0 for read, else 2)
// R03: quad bit ignores hold/wp, allows quad
// R04: ddr quad read only with quad set
// R05: check pulses multiple of eight first; here checked for write commands only, reads execute at any count
// R06: bad count command dropped, no error
// R07: no commands during power-on initialisation
// R08: ignore instructions until powerup delay ends
// R09: host keeps deselected during powerup delay
// R10: after delay, standby not deep power-down
// R11: clear write enable latch at power-up end
// R12: reset pin or command restarts initialisation
// R13: ignore commands while under cut-off voltage
// R14: at low supply treated as powered off
// R15: count pulses over select low, check at rise
module fcg_gate #(
   parameter int unsigned POWERUP_CNT = fcg_pkg::POWERUP_CYCLES
) (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic               cs_n_pin,
   input  wire logic               sck_pin,
   input  wire logic               reset_n_pin,
   input  wire logic               sw_reset,
   input  wire logic               vcc_low,
   input  wire logic               vcc_cutoff,
   input  wire logic [7:0]         config_reg_first,
   input  wire fcg_pkg::fcg_req_t  req,
   input  wire logic               hold_n_pin,
   input  wire logic               wp_n_pin,
   output logic                    ready,
   output logic                    cmd_accept,
   output logic                    cmd_discard,
   output logic                    exec_strobe,
   output fcg_pkg::fcg_cmd_t       exec_cmd,
   output fcg_pkg::fcg_lat_t       lat,
   output logic                    hold_active,
   output logic                    wp_active,
   output logic                    deep_pd,
   output logic                    write_enable_latch_clr
);
   import fcg_pkg::*;

   // ==========================================================
   // synchronisers
   logic [1:0] cs_s_q, cs_s_d, sck_s_q, sck_s_d, rst_s_q, rst_s_d;
   logic [1:0] low_s_q, low_s_d, cut_s_q, cut_s_d;
   logic [1:0] hold_s_q, hold_s_d, wp_s_q, wp_s_d;
   logic       sck_prev_q, sck_prev_d, cs_prev_q, cs_prev_d;

   always_comb begin
      cs_s_d     = {cs_s_q[0], cs_n_pin};
      sck_s_d    = {sck_s_q[0], sck_pin};
      rst_s_d    = {rst_s_q[0], reset_n_pin};
      low_s_d    = {low_s_q[0], vcc_low};
      cut_s_d    = {cut_s_q[0], vcc_cutoff};
      hold_s_d   = {hold_s_q[0], hold_n_pin};
      wp_s_d     = {wp_s_q[0], wp_n_pin};
      sck_prev_d = sck_s_q[1];
      cs_prev_d  = cs_s_q[1];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_s_q     <= 2'h3;
         sck_s_q    <= 2'h0;
         rst_s_q    <= 2'h0;
         low_s_q    <= 2'h3;
         cut_s_q    <= 2'h3;
         hold_s_q   <= 2'h3;
         wp_s_q     <= 2'h3;
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         cs_s_q     <= cs_s_d;
         sck_s_q    <= sck_s_d;
         rst_s_q    <= rst_s_d;
         low_s_q    <= low_s_d;
         cut_s_q    <= cut_s_d;
         hold_s_q   <= hold_s_d;
         wp_s_q     <= wp_s_d;
         sck_prev_q <= sck_prev_d;
         cs_prev_q  <= cs_prev_d;
      end
   end

   // ==========================================================
   // power state
   function automatic fcg_lat_t lat_decode(input logic [1:0] code, input fcg_cmd_t c);
      fcg_lat_t r;
      r.mode_cycles  = (c == FCG_CMD_READ) ? 4'h0 : 4'h2;
      r.dummy_cycles = (c == FCG_CMD_DDRQ) ? 5'({3'h0, code} + 5'h4) : 5'({3'h0, code} + 5'h1);
      if (code == 2'h3 && c != FCG_CMD_DDRQ)
         r.dummy_cycles = 5'h0;
      return r;
   endfunction

   fcg_state_t st_q, st_d;
   logic [31:0] pu_q, pu_d;
   logic        wel_clr_q, wel_clr_d;
   logic        restart;

   always_comb begin
      restart   = !rst_s_q[1] || sw_reset;
      st_d      = st_q;
      pu_d      = pu_q;
      wel_clr_d = 1'b0;
      case (st_q)
         FCG_OFF: begin
            if (!low_s_q[1]) begin                    // [R14]
               st_d = FCG_POR;
               pu_d = 32'h0;
            end
         end
         FCG_POR: begin
            if (pu_q >= POWERUP_CNT - 1) begin        // [R08]
               st_d      = FCG_STANDBY;                // [R10]
               wel_clr_d = 1'b1;                       // [R11]
            end else begin
               pu_d = pu_q + 32'h1;
            end
         end
         FCG_STANDBY: st_d = FCG_STANDBY;
         default:     st_d = FCG_OFF;
      endcase
      if (restart && st_q != FCG_OFF) begin            // [R12]
         st_d = FCG_POR;
         pu_d = 32'h0;
      end
      if (low_s_q[1])                                  // [R14]
         st_d = FCG_OFF;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q      <= FCG_OFF;
         pu_q      <= 32'h0;
         wel_clr_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         pu_q      <= pu_d;
         wel_clr_q <= wel_clr_d;
      end
   end

   // ==========================================================
   // command gating and pulse count
   logic [PULSE_W-1:0] cnt_q, cnt_d;
   fcg_cmd_t           pend_q, pend_d;
   logic               acc_q, acc_d, disc_q, disc_d, ex_q, ex_d;
   fcg_cmd_t           exc_q, exc_d;
   logic               quad, ok, is_write;

   always_comb begin
      quad     = config_reg_first[QUAD_BIT];                          // [R03]
      ok       = st_q == FCG_STANDBY && !cut_s_q[1];                  // [R07] [R13]
      is_write = pend_q inside {FCG_CMD_PROG, FCG_CMD_ERASE, FCG_CMD_WRREG, FCG_CMD_QPP};
      cnt_d    = cnt_q;
      pend_d   = pend_q;
      acc_d    = 1'b0;
      disc_d   = 1'b0;
      ex_d     = 1'b0;
      exc_d    = exc_q;
      if (cs_prev_q && !cs_s_q[1])
         cnt_d = '0;                                                  // [R15]
      else if (!cs_s_q[1] && sck_s_q[1] && !sck_prev_q)
         cnt_d = cnt_q + PULSE_W'(1);                                 // [R15]
      if (req.valid && ok && !cs_s_q[1]) begin
         if ((req.cmd inside {FCG_CMD_QPP, FCG_CMD_QREAD} && !quad)   // [R03]
             || (req.cmd == FCG_CMD_DDRQ && !quad)) begin             // [R04]
            disc_d = 1'b1;
            pend_d = FCG_CMD_NONE;
         end else begin
            acc_d  = 1'b1;
            pend_d = req.cmd;
         end
      end
      if (!cs_prev_q && cs_s_q[1]) begin
         if (pend_q != FCG_CMD_NONE && ok) begin
            if (!is_write || (cnt_q[2:0] & BYTE_MASK) == 3'h0) begin  // [R05]
               ex_d  = 1'b1;
               exc_d = pend_q;
            end else begin
               disc_d = 1'b1;                                         // [R06]
            end
         end
         pend_d = FCG_CMD_NONE;
      end
      if (!ok)
         pend_d = FCG_CMD_NONE;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= '0;
         pend_q <= FCG_CMD_NONE;
         acc_q  <= 1'b0;
         disc_q <= 1'b0;
         ex_q   <= 1'b0;
         exc_q  <= FCG_CMD_NONE;
      end else begin
         cnt_q  <= cnt_d;
         pend_q <= pend_d;
         acc_q  <= acc_d;
         disc_q <= disc_d;
         ex_q   <= ex_d;
         exc_q  <= exc_d;
      end
   end

   // ==========================================================
   // outputs
   fcg_lat_t lat_q, lat_d;
   logic     hold_q, hold_d, wp_q, wp_d;

   always_comb begin
      lat_d  = lat_decode(config_reg_first[LAT_BIT_HI:LAT_BIT_LO], pend_q); // [R01] [R02]
      hold_d = !config_reg_first[QUAD_BIT] && !hold_s_q[1];                 // [R03]
      wp_d   = !config_reg_first[QUAD_BIT] && !wp_s_q[1];                   // [R03]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lat_q  <= '0;
         hold_q <= 1'b0;
         wp_q   <= 1'b0;
      end else begin
         lat_q  <= lat_d;
         hold_q <= hold_d;
         wp_q   <= wp_d;
      end
   end

   assign ready                  = ok;
   assign cmd_accept             = acc_q;
   assign cmd_discard            = disc_q;
   assign exec_strobe            = ex_q;
   assign exec_cmd               = exc_q;
   assign lat                    = lat_q;
   assign hold_active            = hold_q;
   assign wp_active              = wp_q;
   assign deep_pd                = 1'b0;
   assign write_enable_latch_clr = wel_clr_q;
endmodule
`default_nettype wire

/* File: shared/fcg_pkg.sv */
// Purpose: constants and types for flash command gating
// Assumes: 100 MHz system clock
// Notes:   latency table values are plain defaults
`default_nettype none
package fcg_pkg;
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned POWERUP_DELAY_US = 300;
   localparam int unsigned POWERUP_CYCLES   = POWERUP_DELAY_US * CLK_MHZ;
   localparam int unsigned LAT_BIT_HI       = 7;
   localparam int unsigned LAT_BIT_LO       = 6;
   localparam int unsigned QUAD_BIT         = 1;
   localparam int unsigned PULSE_W          = 16;
   localparam logic [2:0]  BYTE_MASK        = 3'h7;

   // command classes decoded by the command parser outside
   typedef enum logic [2:0] {
      FCG_CMD_NONE  = 3'h0,
      FCG_CMD_READ  = 3'h1,
      FCG_CMD_QREAD = 3'h2,
      FCG_CMD_QPP   = 3'h3,
      FCG_CMD_DDRQ  = 3'h4,
      FCG_CMD_PROG  = 3'h5,
      FCG_CMD_ERASE = 3'h6,
      FCG_CMD_WRREG = 3'h7
   } fcg_cmd_t;

   typedef enum logic [1:0] {
      FCG_OFF     = 2'b00,
      FCG_POR     = 2'b01,
      FCG_STANDBY = 2'b11
   } fcg_state_t;

   typedef struct packed {
      logic [3:0] mode_cycles;
      logic [4:0] dummy_cycles;
   } fcg_lat_t;

   typedef struct packed {
      logic       valid;
      fcg_cmd_t   cmd;
   } fcg_req_t;
endpackage
`default_nettype wire

/* File: sim/fcg_gate_checker.sv */
// Purpose: port assertions for flash command gating
// Assumes: bound to fcg_gate
// Notes:   one clock domain
`default_nettype none
module fcg_gate_checker
   import fcg_pkg::*;
(
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       cs_n_pin,
   input wire logic       reset_n_pin,
   input wire logic       vcc_low,
   input wire logic       vcc_cutoff,
   input wire logic [7:0] config_reg_first,
   input wire fcg_req_t   req,
   input wire logic       ready,
   input wire logic       cmd_accept,
   input wire logic       cmd_discard,
   input wire logic       exec_strobe,
   input wire logic       hold_active,
   input wire logic       wp_active,
   input wire logic       deep_pd,
   input wire logic       write_enable_latch_clr
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence cut_held;
      vcc_cutoff [*4];
   endsequence
   sequence low_held;
      vcc_low [*5];
   endsequence
   a_idle_refuse: assert property (!ready |=> !cmd_accept) else $error("accept while not ready");
   a_accept_cause: assert property (cmd_accept |-> $past(req.valid && ready)) else $error("accept no cause");
   a_cutoff_block: assert property (cut_held |-> !ready) else $error("ready under cut-off");
   a_low_off: assert property (low_held |-> !ready && !exec_strobe) else $error("alive at low supply");
   a_restart_init: assert property (!reset_n_pin [*4] |-> !ready) else $error("ready in reset");
   a_quad_pins:
      assert property (config_reg_first[QUAD_BIT] |=> !hold_active && !wp_active) else $error("pins active");
   a_ddr_gate:
      assert property (req.valid && req.cmd == FCG_CMD_DDRQ && !config_reg_first[QUAD_BIT] |=> !cmd_accept)
      else $error("ddr quad taken");
   a_exec_close:
      assert property (exec_strobe |-> cs_n_pin && $past(cs_n_pin, 3) && !cmd_discard) else $error("early exec");
   a_wel_standby:
      assert property (write_enable_latch_clr |-> !deep_pd ##1 !write_enable_latch_clr) else $error("bad wel");
endmodule
bind fcg_gate fcg_gate_checker u_chk (.*);
`default_nettype wire

/* File: sim/fcg_host.sv */
// Purpose: host model driving select and serial clock
// Assumes: start only while idle
// Notes:   sck idles low outside frames
`default_nettype none
module fcg_host (
   input  wire logic       clk,
   input  wire logic       start,
   input  wire logic [6:0] pulses,
   output logic            cs_n_pin,
   output logic            sck_pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] ph;
   initial {cs_n_pin, sck_pin, busy, ph} = 13'h1000;
   always @(posedge clk) begin
      ph <= busy ? ph + 10'h1 : 10'h0;
      if (start) busy <= 1'b1;
      if (ph == 10'h1C + 4 * pulses) busy <= 1'b0;
      cs_n_pin <= !(start || busy && ph < 10'h10 + 4 * pulses);
      sck_pin <= busy && ph >= 10'h8 && ph < 10'h8 + 4 * pulses && ph[1];
   end
endmodule
`default_nettype wire

/* File: sim/fcg_gate_tb_top.sv */
// Purpose: self-checking bench for flash command gating
// Assumes: fcg_host drives select and clock
// Notes:   power-up count cut to 20
`default_nettype none
module fcg_gate_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import fcg_pkg::*;
   logic clk = 0, arst_n = 0, rp_n = 1, swr = 0, vlo = 0, vcut = 0, hn = 1, wn = 1, start = 0;
   logic acc, dis, exs, write_enable_latch, busy, cs_n, sck, rdy, dpd, ha, wa;
   logic [6:0] pul = 0;
   logic [7:0] cfg = 0;
   fcg_req_t req = '0;
   fcg_cmd_t xcmd;
   fcg_lat_t lat;
   int error_cnt = 0, compares = 0;
   always #5 clk = ~clk;
   fcg_host u_host (.clk(clk), .start(start), .pulses(pul), .cs_n_pin(cs_n), .sck_pin(sck), .busy(busy));
   fcg_gate #(.POWERUP_CNT(20)) DUT (.clk(clk), .arst_n(arst_n), .cs_n_pin(cs_n), .sck_pin(sck),
      .reset_n_pin(rp_n), .sw_reset(swr), .vcc_low(vlo), .vcc_cutoff(vcut), .config_reg_first(cfg),
      .req(req), .hold_n_pin(hn), .wp_n_pin(wn), .ready(rdy), .cmd_accept(acc), .cmd_discard(dis),
      .exec_strobe(exs), .exec_cmd(xcmd), .lat(lat), .hold_active(ha), .wp_active(wa), .deep_pd(dpd),
      .write_enable_latch_clr(write_enable_latch));
   task automatic close_out;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check(logic [15:0] s, logic [15:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [1:0] exp_out(fcg_cmd_t c, int p, logic q);
      logic a;
      a = q || !(c inside {FCG_CMD_QREAD, FCG_CMD_QPP, FCG_CMD_DDRQ});
      return {a, a && c != FCG_CMD_NONE && (p % 8 == 0 || c inside {FCG_CMD_READ, FCG_CMD_QREAD, FCG_CMD_DDRQ})};
   endfunction
   function automatic fcg_lat_t lat_exp(fcg_cmd_t c, logic [1:0] k);
      fcg_lat_t l;
      l.mode_cycles = (c == FCG_CMD_READ) ? 4'h0 : 4'h2;
      l.dummy_cycles = (c == FCG_CMD_DDRQ) ? 5'(k) + 5'h4 : (k == 2'h3) ? 5'h0 : 5'(k) + 5'h1;
      return l;
   endfunction
   task automatic pwr_wait;
      int i;
      for (i = 0; i < 400 && write_enable_latch !== 1'b1; i++) step(1);
      if (i == 400) begin
         error_cnt++;
         close_out;
      end
      check(i >= 20, 1);
      step(1);
      check({rdy, dpd}, 2'b10);
   endtask
   task automatic frame(fcg_cmd_t c, int p, logic q);
      logic [1:0] e;
      logic ex, ds;
      fcg_lat_t lt;
      int i;
      e = exp_out(c, p, q);
      {ex, ds, lt} = '0;
      cfg = 8'($urandom);
      cfg[QUAD_BIT] = q;
      {hn, wn} = 2'($urandom);
      pul = 7'(p);
      start = 1;
      step(1);
      start = 0;
      step(5);
      req = '{1'b1, c};
      step(1);
      req.valid = 0;
      check({acc, dis}, {e[1], !e[1]});
      for (i = 0; i < 300 && busy; i++) begin
         step(1);
         if (exs) lt = lat;
         ex |= exs;
         ds |= dis;
      end
      if (busy) begin
         error_cnt++;
         close_out;
      end
      check(ex, e[0]);
      check(ds, e[1] && !e[0] && c != FCG_CMD_NONE);
      check({ha, wa}, {!q && !hn, !q && !wn});
      if (ex) check(xcmd, c);
      if (ex && c inside {FCG_CMD_READ, FCG_CMD_QREAD, FCG_CMD_DDRQ}) check(lt, lat_exp(c, cfg[7:6]));
   endtask
   initial begin
      void'($urandom(32'h84870C15));
      step(16);
      arst_n = 1;
      req = '{1'b1, FCG_CMD_PROG};
      check(rdy, 0);
      pwr_wait;
      req = '0;
      frame(FCG_CMD_DDRQ, 8, 0);
      frame(FCG_CMD_WRREG, 9, 1);
      frame(FCG_CMD_PROG, 7, 1);
      for (int k = 1; k < 16; k++) frame(fcg_cmd_t'(k % 8), $urandom_range(1, 24), k > 7);
      for (int k = 0; k < 4; k++) begin
         {vcut, rp_n, swr, vlo} = {k == 0, k != 1, k == 2, k == 3};
         step(6);
         check(rdy, 0);
         {vcut, rp_n, swr, vlo} = 4'h4;
         if (k == 0) step(6);
         else pwr_wait;
         check(rdy, 1);
         frame(FCG_CMD_ERASE, 16, 1);
      end
      close_out;
   end
endmodule
`default_nettype wire
